// ---- common/efh_consts.svh ----
// Constants for the Ethernet frame handling block: offsets, fields, frame sizes.
// Assumes inclusion by bare name from design and testbench files.
`ifndef EFH_CONSTS_SVH
`define EFH_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define EFH_OFS_CTRL 12'h000
`define EFH_OFS_ADDR_LO 12'h004
`define EFH_OFS_ADDR_HI 12'h008
`define EFH_OFS_TXDATA 12'h00C
`define EFH_OFS_STATUS 12'h010
`define EFH_OFS_RXSTAT 12'h014

// ----------------------------------------------------------------------------
// Register fields and reset values
// ----------------------------------------------------------------------------
`define EFH_CTRL_RST 8'h00
`define EFH_CTRL_PAD 0
`define EFH_CTRL_CFG_HI 2
`define EFH_CTRL_HUGE 3
`define EFH_CTRL_CRCF 4
`define EFH_CTRL_UC 5
`define EFH_CTRL_MC 6
`define EFH_CTRL_BC 7
`define EFH_TXD_LAST 8
`define EFH_ST_TRUNC 3
`define EFH_RSV_CRC 16
`define EFH_RSV_MC 17
`define EFH_RSV_BC 18
`define EFH_RSV_UC 19

// ----------------------------------------------------------------------------
// Frame constants
// ----------------------------------------------------------------------------
`define EFH_PRE_BYTE 8'h55
`define EFH_SFD_BYTE 8'hD5
`define EFH_PAD_BYTE 8'h00
`define EFH_PRE_LAST 3'h6
`define EFH_FCS_LAST 2'h3
`define EFH_DEST_LAST 16'h0006
`define EFH_MIN_NOFCS 16'h003C
`define EFH_RUNT_MIN 16'h0012
`define EFH_TX_STD_MAX 16'h05EA
`define EFH_RX_STD_MAX 16'h05EE
`define EFH_CNT_SAT 16'hFFFF
`define EFH_BCAST 48'hFFFFFFFFFFFF

// ----------------------------------------------------------------------------
// CRC-32, reflected form
// ----------------------------------------------------------------------------
`define EFH_CRC_INIT 32'hFFFFFFFF
`define EFH_CRC_POLY 32'hEDB88320
`define EFH_CRC_RESIDUE 32'hDEBB20E3

`endif

// ---- common/efh_crc_if.sv ----
// Carrier between the frame logic and one CRC engine.
// Assumes both ends on the same pclk domain.
`timescale 1ns/10ps
interface efh_crc_if;
  logic init;
  logic en;
  logic [7:0] data;
  logic [31:0] crc;
  logic good;
  modport user (output init, output en, output data, input crc, input good);
  modport engine (input init, input en, input data, output crc, output good);
endinterface

// ---- common/efh_pkg.sv ----
// Types shared by the Ethernet frame handling design files.
// Assumes efh_consts.svh on the include path.
package efh_pkg;

  // --------------------------------------------------------------------------
  // State and register select encodings
  // --------------------------------------------------------------------------
  typedef enum logic [5:0] {
    TX_IDLE = 6'b000001,
    TX_PRE = 6'b000010,
    TX_SFD = 6'b000100,
    TX_DATA = 6'b001000,
    TX_PAD = 6'b010000,
    TX_FCS = 6'b100000
  } efh_tx_state_e;

  typedef enum logic [2:0] {
    RX_HUNT = 3'b001,
    RX_FRAME = 3'b010,
    RX_DONE = 3'b100
  } efh_rx_state_e;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_CTRL = 3'h1,
    SEL_ADDR_LO = 3'h2,
    SEL_ADDR_HI = 3'h3,
    SEL_TXDATA = 3'h4,
    SEL_STATUS = 3'h5,
    SEL_RXSTAT = 3'h6
  } efh_sel_e;

endpackage

// ---- tb/efh_medium.sv ----
// Medium model: takes transmit bytes, sends receive frames.
// Assumes byte streams on pclk; bench sets slow and calls send.
`timescale 1ns/10ps
module efh_medium (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Transmit side
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Receive side
  output logic rx_valid,
  output logic rx_last,
  output logic [7:0] rx_data
);
  logic [7:0] txq[$];
  logic slow = 1'b0;
  int done = 0;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = 8'h00;
  end
  // Stalls every other cycle when slow
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        txq.push_back(tx_data);
        if (tx_last) done++;
      end
    end
  end
  task automatic send(input logic [7:0] q[$]);
    for (int i = 0; i < q.size() + 8; i++) begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data <= i < 7 ? 8'h55 : (i == 7 ? 8'hD5 : q[i - 8]);
      rx_last <= i == q.size() + 7;
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
  endtask
endmodule // efh_medium

// ---- tb/efh_top_chk.sv ----
// Checker of frame timing at the efh_top pins.
// Assumes one pclk domain and bind onto efh_top.
`timescale 1ns/10ps
module efh_top_chk (
  // Clock, reset and APB
  input wire logic pclk, presetn, psel, penable, pwrite, pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Streams
  input wire logic tx_valid, tx_last, tx_ready, rx_valid, rx_last, rxb_we, rxb_commit, rxb_abort,
  input wire logic [7:0] tx_data, rx_data, rxb_data
);
  logic [15:0] ti_q, ti_d, rl_q, rl_d;
  logic [7:0] ctl_q, ctl_d;
  logic hunt_q, hunt_d;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Byte index on transmit, frame length and hunt state on receive
  always_comb begin
    ti_d = ti_q;
    if (tx_valid && tx_ready) ti_d = tx_last ? 16'h0000 : ti_q + 16'h0001;
    rl_d = hunt_q ? 16'h0000 : rl_q + {15'h0000, rx_valid};
    hunt_d = hunt_q;
    if (rx_valid && hunt_q && !rx_last && rx_data == 8'hD5) hunt_d = 1'b0;
    if (rx_valid && !hunt_q && rx_last) hunt_d = 1'b1;
    ctl_d = ctl_q;
    if (psel && penable && pready && pwrite && paddr == 12'h000) ctl_d = pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ti_q <= 16'h0000;
      rl_q <= 16'h0000;
      ctl_q <= 8'h00;
      hunt_q <= 1'b1;
    end else begin
      ti_q <= ti_d;
      rl_q <= rl_d;
      ctl_q <= ctl_d;
      hunt_q <= hunt_d;
    end
  end
  AST_TX_PRE: assert property (tx_valid && ti_q < 16'h0007 |-> tx_data == 8'h55)
    else $error("preamble byte wrong");
  AST_TX_SFD: assert property (tx_valid && ti_q == 16'h0007 |-> tx_data == 8'hD5 && !tx_last)
    else $error("delimiter byte wrong");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("transmit byte not held");
  AST_TX_PAD: assert property (tx_valid && tx_ready && tx_last && ctl_q[0] |-> ti_q >= 16'h0047)
    else $error("padded frame too short");
  AST_RX_STRIP: assert property (hunt_q && rx_valid |=> !rxb_we)
    else $error("preamble byte stored");
  AST_RX_STORE: assert property (rxb_we |-> !$past(hunt_q) && $past(rx_valid) && rxb_data == $past(rx_data))
    else $error("stored byte differs");
  AST_RX_RUNT: assert property (rx_valid && rx_last && !hunt_q && rl_q < 16'h0011 |-> ##2 rxb_abort && !rxb_commit)
    else $error("runt not dropped");
  AST_RX_HUGE: assert property (rx_valid && rx_last && !hunt_q && rl_q > 16'h05ED && !ctl_q[3] |-> ##2 rxb_abort)
    else $error("long frame not dropped");
  AST_RX_END: assert property (rx_valid && rx_last && !hunt_q |-> ##2 rxb_commit != rxb_abort)
    else $error("no single frame verdict");
endmodule // efh_top_chk

bind efh_top efh_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata), .tx_valid(tx_valid),
  .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_last(rx_last), .rxb_we(rxb_we),
  .rxb_commit(rxb_commit), .rxb_abort(rxb_abort), .tx_data(tx_data), .rx_data(rx_data), .rxb_data(rxb_data));

// ---- tb/efh_top_tb_top.sv ----
// Testbench: APB host and medium model around efh_top.
// Assumes 20 MHz pclk; inputs change by NBA at rising edge.
`timescale 1ns/10ps
`include "efh_consts.svh"
module efh_top_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, tx_valid, tx_last, tx_ready, rx_valid, rx_last, rxb_we, rxb_commit, rxb_abort;
  logic [7:0] tx_data, rx_data, rxb_data;
  logic [7:0] fr[$], ex[$];
  int err_total = 0, compares = 0, nwe = 0, nend = 0, ncom = 0;
  localparam logic [47:0] LA = 48'h0A1B2C3D4E5F;
  always #25 pclk = ~pclk;
  efh_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rxb_we(rxb_we), .rxb_data(rxb_data), .rxb_commit(rxb_commit),
    .rxb_abort(rxb_abort));
  efh_medium med (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx_last(tx_last), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_last(rx_last), .rx_data(rx_data));
  always @(posedge pclk) begin
    if (rxb_we === 1'b1) nwe <= nwe + 1;
    if (rxb_commit === 1'b1 || rxb_abort === 1'b1) nend <= nend + 1;
    if (rxb_commit === 1'b1) ncom <= ncom + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic results();
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // APB transfer; answer taken where pready is high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) chk({31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [7:0] hb(input int i);
    return i < 12 ? 8'hA0 + 8'(i) : 8'(i);
  endfunction
  function automatic logic [31:0] crc(input logic [7:0] q[$]);
    logic [31:0] c = `EFH_CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {24'h000000, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ `EFH_CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  task automatic addfcs(ref logic [7:0] q[$], input logic [31:0] c);
    for (int k = 0; k < 4; k++) q.push_back(~c[8 * k +: 8]);
  endtask
  // Transmit n host bytes, compare the wire
  task automatic txc(input int n, input logic [2:0] cfg, input logic sl);
    int d0;
    apb(1'b1, `EFH_OFS_CTRL, {29'h0, cfg});
    med.slow <= sl;
    med.txq.delete();
    d0 = med.done;
    ex.delete();
    for (int i = 0; i < 8; i++) ex.push_back(i < 7 ? 8'h55 : 8'hD5);
    for (int i = 0; i < n; i++) begin
      apb(1'b1, `EFH_OFS_TXDATA, {23'h0, i == n - 1, hb(i)});
      if (i < 1514 || i == n - 1) ex.push_back(hb(i));
    end
    while (cfg[0] && ex.size() < 68) ex.push_back(8'h00);
    if (cfg != 3'h0) addfcs(ex, crc(ex[8:$]));
    for (int i = 0; i < 20000 && med.done == d0; i++) @(negedge pclk);
    chk(32'(med.txq.size()), 32'(ex.size()));
    foreach (ex[i]) chk({24'h0, med.txq[i]}, {24'h0, ex[i]});
    apb(1'b0, `EFH_OFS_STATUS, 32'h0);
    chk({31'h0, rd[3]}, {31'h0, n > 1514});
    apb(1'b1, `EFH_OFS_STATUS, 32'h8);
  endtask
  // Receive one frame of n bytes, check verdict and status
  task automatic rxc(input logic [7:0] ctl, input logic [47:0] da, input int n, input logic good, input logic acc);
    int w0, c0, e0;
    apb(1'b1, `EFH_OFS_CTRL, {24'h0, ctl});
    fr.delete();
    for (int i = 0; i < n - 4; i++) fr.push_back(i < 6 ? da[47 - 8 * i -: 8] : 8'(i));
    addfcs(fr, crc(fr) ^ {31'h0, !good});
    w0 = nwe;
    c0 = ncom;
    e0 = nend;
    med.send(fr);
    for (int i = 0; i < 50 && nend == e0; i++) @(negedge pclk);
    chk(32'(ncom - c0), {31'h0, acc});
    if (acc) begin
      chk(32'(nwe - w0), 32'(n));
      apb(1'b0, `EFH_OFS_RXSTAT, 32'h0);
      chk({12'h0, rd[19:0]}, {12'h0, da == LA, da == `EFH_BCAST, da[40], good, 16'(n)});
    end
    repeat (2) @(posedge pclk);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `EFH_OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, `EFH_OFS_ADDR_LO, 32'h3D2C1B0A);
    apb(1'b1, `EFH_OFS_ADDR_HI, 32'h00005F4E);
    txc(20, 3'h1, 1'b1);
    txc(20, 3'h0, 1'b0);
    txc(20, 3'h2, 1'b1);
    txc(1516, 3'h0, 1'b0);
    rxc(8'h30, LA, 24, 1'b1, 1'b1);
    rxc(8'h10, LA, 24, 1'b0, 1'b0);
    rxc(8'h00, LA, 17, 1'b1, 1'b0);
    rxc(8'h00, LA, 18, 1'b0, 1'b1);
    rxc(8'h80, `EFH_BCAST, 64, 1'b1, 1'b1);
    rxc(8'h20, 48'h010000000000, 64, 1'b1, 1'b0);
    rxc(8'h40, 48'h010000000000, 64, 1'b1, 1'b1);
    rxc(8'h00, LA, 1519, 1'b1, 1'b0);
    rxc(8'h08, LA, 1519, 1'b1, 1'b1);
    results();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    results();
  end
endmodule // efh_top_tb_top

// ---- verilog/efh_crc.sv ----
// Byte-wide CRC-32 engine, least significant bit first.
// Assumes init and en are never high together with different intent; init wins.
`timescale 1ns/10ps
`include "efh_consts.svh"
module efh_crc (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Engine side
  efh_crc_if.engine c
);
  import efh_pkg::*;

  logic [31:0] crc_q;
  logic [31:0] crc_d;
  logic [31:0] mix;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    mix = crc_q ^ {24'h000000, c.data};
    for (int i = 0; i < 8; i++) begin
      mix = mix[0] ? ((mix >> 1) ^ `EFH_CRC_POLY) : (mix >> 1);
    end
    crc_d = crc_q;
    if (c.init) begin
      crc_d = `EFH_CRC_INIT;
    end else if (c.en) begin
      crc_d = mix;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_q <= `EFH_CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign c.crc = crc_q;
  assign c.good = (crc_q == `EFH_CRC_RESIDUE);

endmodule // efh_crc

// ---- verilog/efh_top.sv ----
// Ethernet frame handling: APB registers, transmit framing, receive checking.
// Assumes medium byte streams and receive buffer port run on pclk.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`include "efh_consts.svh"
// Function
// - Send seven preamble bytes and delimiter before each frame; strip them on receive.
// - Preamble and delimiter made and removed by hardware only, never via buffer.
// - Accepted receive frames keep padding and four CRC bytes in buffer.
// - Destination with first byte bit zero set is multicast, else unicast.
// - All-ones destination is broadcast, a special multicast.
// - Separate accept filters for unicast, multicast and broadcast destinations.
// - Station address only feeds unicast filter; source sent as written.
// - Data field limited to 1500 bytes unless huge frames enabled; transmit still sends the last host byte after the first 1514, so 1501.
// - Standard frame 64 to 1518 bytes; 60 before CRC; short data padded.
// - Pad configuration selects zero padding of short transmit frames.
// - Undersize frames sent as commanded when padding off, no flag.
// - Received frames under 18 bytes dropped; others go to filtering.
// - Frame check is standard CRC-32 over destination through padding.
// - CRC checked on every frame; discard bad ones when CRC filter enabled.
// - With CRC filter off, store frame and report CRC validity in status.
// - Configuration selects hardware CRC append, else host supplies CRC.
module efh_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit byte stream to medium
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  // Receive byte stream from medium
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  // Receive packet buffer write port
  output logic rxb_we,
  output logic [7:0] rxb_data,
  output logic rxb_commit,
  output logic rxb_abort
);
  import efh_pkg::*;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic efh_sel_e efh_decode(input logic [11:0] a);
    if (a == `EFH_OFS_CTRL) begin
      return SEL_CTRL;
    end else if (a == `EFH_OFS_ADDR_LO) begin
      return SEL_ADDR_LO;
    end else if (a == `EFH_OFS_ADDR_HI) begin
      return SEL_ADDR_HI;
    end else if (a == `EFH_OFS_TXDATA) begin
      return SEL_TXDATA;
    end else if (a == `EFH_OFS_STATUS) begin
      return SEL_STATUS;
    end else if (a == `EFH_OFS_RXSTAT) begin
      return SEL_RXSTAT;
    end else begin
      return SEL_NONE;
    end
  endfunction

  efh_crc_if txc ();
  efh_crc_if rxc ();

  efh_crc u_tx_crc (.pclk(pclk), .presetn(presetn), .c(txc));
  efh_crc u_rx_crc (.pclk(pclk), .presetn(presetn), .c(rxc));

  efh_sel_e sel;
  logic access;
  logic wr;
  logic [7:0] ctrl_q, ctrl_d;
  logic [31:0] addr_lo_q, addr_lo_d;
  logic [15:0] addr_hi_q, addr_hi_d;
  logic [31:0] prdata_q, prdata_d;
  logic [7:0] hold_q, hold_d;
  logic hold_last_q, hold_last_d;
  logic hold_full_q, hold_full_d;
  logic trunc_q, trunc_d;
  efh_tx_state_e tx_state_q, tx_state_d;
  logic [2:0] pcnt_q, pcnt_d;
  logic [1:0] fcnt_q, fcnt_d;
  logic [15:0] tcnt_q, tcnt_d;
  logic tx_valid_q, tx_valid_d;
  logic [7:0] tx_data_q, tx_data_d;
  logic tx_last_q, tx_last_d;
  logic out_free;
  logic pad_en;
  logic crc_app;
  logic huge;
  logic over;
  efh_rx_state_e rx_state_q, rx_state_d;
  logic [15:0] rcnt_q, rcnt_d;
  logic [47:0] dest_q, dest_d;
  logic [19:0] rsv_q, rsv_d;
  logic rxb_we_q, rxb_we_d;
  logic [7:0] rxb_data_q, rxb_data_d;
  logic rxb_commit_q, rxb_commit_d;
  logic rxb_abort_q, rxb_abort_d;
  logic is_mc, is_bc, is_uc, pass, keep;

  assign sel = efh_decode(paddr);
  assign access = psel & penable;
  assign pready = !(access & pwrite & (sel == SEL_TXDATA) & hold_full_q);
  assign pslverr = access & (sel == SEL_NONE);
  assign wr = access & pwrite & pready & (sel != SEL_NONE);
  assign pad_en = ctrl_q[`EFH_CTRL_PAD];
  assign crc_app = |ctrl_q[`EFH_CTRL_CFG_HI:`EFH_CTRL_PAD];
  assign huge = ctrl_q[`EFH_CTRL_HUGE];
  assign out_free = !tx_valid_q | tx_ready;
  assign over = !huge & (tcnt_q >= `EFH_TX_STD_MAX);

  // --------------------------------------------------------------------------
  // Registers and transmit framing
  // --------------------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    addr_lo_d = addr_lo_q;
    addr_hi_d = addr_hi_q;
    hold_d = hold_q;
    hold_last_d = hold_last_q;
    hold_full_d = hold_full_q;
    trunc_d = trunc_q;
    prdata_d = prdata_q;
    tx_state_d = tx_state_q;
    pcnt_d = pcnt_q;
    fcnt_d = fcnt_q;
    tcnt_d = tcnt_q;
    tx_valid_d = tx_valid_q & !tx_ready;
    tx_data_d = tx_data_q;
    tx_last_d = tx_last_q;
    txc.init = 1'b0;
    txc.en = 1'b0;
    txc.data = `EFH_PAD_BYTE;
    if (psel & !penable) begin
      if (sel == SEL_CTRL) begin
        prdata_d = {24'h000000, ctrl_q};
      end else if (sel == SEL_ADDR_LO) begin
        prdata_d = addr_lo_q;
      end else if (sel == SEL_ADDR_HI) begin
        prdata_d = {16'h0000, addr_hi_q};
      end else if (sel == SEL_TXDATA) begin
        prdata_d = {23'h000000, hold_last_q, hold_q};
      end else if (sel == SEL_STATUS) begin
        prdata_d = {28'h0000000, trunc_q, (rx_state_q != RX_HUNT), hold_full_q, (tx_state_q != TX_IDLE)};
      end else if (sel == SEL_RXSTAT) begin
        prdata_d = {12'h000, rsv_q};
      end else begin
        prdata_d = 32'h00000000;
      end
    end
    if (wr) begin
      if (sel == SEL_CTRL) begin
        ctrl_d = pwdata[7:0];
      end else if (sel == SEL_ADDR_LO) begin
        addr_lo_d = pwdata;
      end else if (sel == SEL_ADDR_HI) begin
        addr_hi_d = pwdata[15:0];
      end else if (sel == SEL_TXDATA) begin
        hold_d = pwdata[7:0];
        hold_last_d = pwdata[`EFH_TXD_LAST];
        hold_full_d = 1'b1;
      end else if (sel == SEL_STATUS) begin
        if (pwdata[`EFH_ST_TRUNC]) begin
          trunc_d = 1'b0;
        end
      end
    end
    case (tx_state_q)
      TX_IDLE: begin
        if (hold_full_q) begin
          tx_state_d = TX_PRE;
          pcnt_d = 3'h0;
        end
      end
      TX_PRE: begin
        if (out_free) begin
          tx_valid_d = 1'b1;
          tx_data_d = `EFH_PRE_BYTE;
          tx_last_d = 1'b0;
          if (pcnt_q == `EFH_PRE_LAST) begin
            tx_state_d = TX_SFD;
          end else begin
            pcnt_d = pcnt_q + 3'h1;
          end
        end
      end
      TX_SFD: begin
        if (out_free) begin
          tx_valid_d = 1'b1;
          tx_data_d = `EFH_SFD_BYTE;
          tx_last_d = 1'b0;
          txc.init = 1'b1;
          tcnt_d = 16'h0000;
          tx_state_d = TX_DATA;
        end
      end
      TX_DATA: begin
        if (out_free & hold_full_q) begin
          hold_full_d = 1'b0;
          tcnt_d = (tcnt_q == `EFH_CNT_SAT) ? tcnt_q : tcnt_q + 16'h0001;
          if (over) begin
            trunc_d = 1'b1;
          end
          if (!over | hold_last_q) begin
            tx_valid_d = 1'b1;
            tx_data_d = hold_q;
            tx_last_d = 1'b0;
            txc.en = 1'b1;
            txc.data = hold_q;
          end
          if (hold_last_q) begin
            if (pad_en & (tcnt_d < `EFH_MIN_NOFCS)) begin
              tx_state_d = TX_PAD;
            end else if (crc_app) begin
              tx_state_d = TX_FCS;
              fcnt_d = 2'h0;
            end else begin
              tx_last_d = 1'b1;
              tx_state_d = TX_IDLE;
            end
          end
        end
      end
      TX_PAD: begin
        if (out_free) begin
          tx_valid_d = 1'b1;
          tx_data_d = `EFH_PAD_BYTE;
          tx_last_d = 1'b0;
          txc.en = 1'b1;
          tcnt_d = tcnt_q + 16'h0001;
          if (tcnt_d == `EFH_MIN_NOFCS) begin
            tx_state_d = TX_FCS;
            fcnt_d = 2'h0;
          end
        end
      end
      TX_FCS: begin
        if (out_free) begin
          tx_valid_d = 1'b1;
          tx_data_d = ~txc.crc[{fcnt_q, 3'b000} +: 8];
          tx_last_d = (fcnt_q == `EFH_FCS_LAST);
          if (fcnt_q == `EFH_FCS_LAST) begin
            tx_state_d = TX_IDLE;
          end else begin
            fcnt_d = fcnt_q + 2'h1;
          end
        end
      end
      default: begin
        tx_state_d = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `EFH_CTRL_RST;
      addr_lo_q <= 32'h00000000;
      addr_hi_q <= 16'h0000;
      hold_q <= 8'h00;
      hold_last_q <= 1'b0;
      hold_full_q <= 1'b0;
      trunc_q <= 1'b0;
      prdata_q <= 32'h00000000;
      tx_state_q <= TX_IDLE;
      pcnt_q <= 3'h0;
      fcnt_q <= 2'h0;
      tcnt_q <= 16'h0000;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_last_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      addr_lo_q <= addr_lo_d;
      addr_hi_q <= addr_hi_d;
      hold_q <= hold_d;
      hold_last_q <= hold_last_d;
      hold_full_q <= hold_full_d;
      trunc_q <= trunc_d;
      prdata_q <= prdata_d;
      tx_state_q <= tx_state_d;
      pcnt_q <= pcnt_d;
      fcnt_q <= fcnt_d;
      tcnt_q <= tcnt_d;
      tx_valid_q <= tx_valid_d;
      tx_data_q <= tx_data_d;
      tx_last_q <= tx_last_d;
    end
  end

  // --------------------------------------------------------------------------
  // Receive checking and filtering
  // --------------------------------------------------------------------------
  assign is_mc = dest_q[0];
  assign is_bc = (dest_q == `EFH_BCAST);
  assign is_uc = !dest_q[0] & (dest_q == {addr_hi_q, addr_lo_q});
  assign pass = (ctrl_q[`EFH_CTRL_BC:`EFH_CTRL_UC] == 3'h0) | (is_bc & ctrl_q[`EFH_CTRL_BC]) |
                (is_mc & !is_bc & ctrl_q[`EFH_CTRL_MC]) | (is_uc & ctrl_q[`EFH_CTRL_UC]);
  assign keep = (rcnt_q >= `EFH_RUNT_MIN) & pass &
                (huge | (rcnt_q <= `EFH_RX_STD_MAX)) &
                (rxc.good | !ctrl_q[`EFH_CTRL_CRCF]);

  always_comb begin
    rx_state_d = rx_state_q;
    rcnt_d = rcnt_q;
    dest_d = dest_q;
    rsv_d = rsv_q;
    rxb_we_d = 1'b0;
    rxb_data_d = rxb_data_q;
    rxb_commit_d = 1'b0;
    rxb_abort_d = 1'b0;
    rxc.init = 1'b0;
    rxc.en = 1'b0;
    rxc.data = rx_data;
    case (rx_state_q)
      RX_HUNT: begin
        if (rx_valid & !rx_last & (rx_data == `EFH_SFD_BYTE)) begin
          rx_state_d = RX_FRAME;
          rxc.init = 1'b1;
          rcnt_d = 16'h0000;
        end
      end
      RX_FRAME: begin
        if (rx_valid) begin
          rxb_we_d = 1'b1;
          rxb_data_d = rx_data;
          rxc.en = 1'b1;
          rcnt_d = (rcnt_q == `EFH_CNT_SAT) ? rcnt_q : rcnt_q + 16'h0001;
          if (rcnt_q < `EFH_DEST_LAST) begin
            dest_d = {rx_data, dest_q[47:8]};
          end
          if (rx_last) begin
            rx_state_d = RX_DONE;
          end
        end
      end
      RX_DONE: begin
        rx_state_d = RX_HUNT;
        rxb_commit_d = keep;
        rxb_abort_d = !keep;
        if (keep) begin
          rsv_d = {is_uc, is_bc, is_mc, rxc.good, rcnt_q};
        end
      end
      default: begin
        rx_state_d = RX_HUNT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q <= RX_HUNT;
      rcnt_q <= 16'h0000;
      dest_q <= 48'h000000000000;
      rsv_q <= 20'h00000;
      rxb_we_q <= 1'b0;
      rxb_data_q <= 8'h00;
      rxb_commit_q <= 1'b0;
      rxb_abort_q <= 1'b0;
    end else begin
      rx_state_q <= rx_state_d;
      rcnt_q <= rcnt_d;
      dest_q <= dest_d;
      rsv_q <= rsv_d;
      rxb_we_q <= rxb_we_d;
      rxb_data_q <= rxb_data_d;
      rxb_commit_q <= rxb_commit_d;
      rxb_abort_q <= rxb_abort_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign prdata = prdata_q;
  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign tx_last = tx_last_q;
  assign rxb_we = rxb_we_q;
  assign rxb_data = rxb_data_q;
  assign rxb_commit = rxb_commit_q;
  assign rxb_abort = rxb_abort_q;

endmodule // efh_top
